// ### src/sysctl_reset_clock.sv
/*
 * Reset-cause record with sticky write-one-to-clear flags, and the
 * programmable peripheral clock divider behind a simple register port.
 * Assumes: reset source inputs are raw levels from outside the clock
 * domain; watchdog inputs and idle/pll inputs come from logic on clock;
 * power-on reset is presented on por_active, not only via rst_n.
 */
// How it works
// [R1] writing one clears a cause flag
// [R2] power-on sets bits 0 and 3, clears others
// [R3] source held after power-on sets its flag
// [R4] only power-on or software alter bit 0
// [R5] external pin sets bit 1, power-on clears
// [R6] watchdog and brown-out leave bit 1
// [R7] watchdog timeout with enable sets bit 2
// [R8] any non-watchdog reset clears bit 2
// [R9] supply below threshold sets bit 3
// [R10] bit 3 set along with power-on
// [R11] external and watchdog leave bit 3
// [R12] software writes zero to upper bits
// [R13] ratio field picks quarter, full or half
// [R14] reserved ratio code write is ignored
// [R15] ratio field resets to zero
// [R16] keep pll running through idle
// [R17] ratio switches only at period boundary
// [R18] reset event beats same-cycle software clear
`timescale 1ns/10ps
module sysctl_reset_clock (
   input  wire logic        clock,
   input  wire logic        rst_n,
   // register port
   input  wire logic [31:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // reset sources from outside the clock domain
   input  wire logic        por_active,
   input  wire logic        ext_reset_active,
   input  wire logic        supply_below_threshold,
   // watchdog, on clock
   input  wire logic        watchdog_timeout,
   input  wire logic        watchdog_reset_enable,
   // power mode, on clock
   input  wire logic        idle_mode,
   input  wire logic        pll_running,
   output logic             pll_keep_running,
   // peripheral clock
   output logic             pclk_en,
   output logic             pclk_phase,
   output logic      [1:0]  active_ratio
);

   clk_div_if dvif ();

   // ---- input synchronisers
   logic [sysctl_pkg::NUM_SYNC-1:0] raw_in;
   logic [sysctl_pkg::NUM_SYNC-1:0] s1_q;
   logic [sysctl_pkg::NUM_SYNC-1:0] s2_q;
   logic [sysctl_pkg::NUM_SYNC-1:0] s3_q;
   logic [sysctl_pkg::NUM_SYNC-1:0] filt_q;

   assign raw_in[sysctl_pkg::SYNC_POR] = por_active;
   assign raw_in[sysctl_pkg::SYNC_EXT] = ext_reset_active;
   assign raw_in[sysctl_pkg::SYNC_BOD] = supply_below_threshold;

   // three stages; the level moves on once stages two and three agree.
   // these run free of rst_n so a chip reset caused by a source
   // does not blind the record to that same source.
   genvar gi;
   generate
      for (gi = 0; gi < sysctl_pkg::NUM_SYNC; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            s1_q[gi] <= raw_in[gi];
            s2_q[gi] <= s1_q[gi];
            s3_q[gi] <= s2_q[gi];
            if (s2_q[gi] == s3_q[gi]) begin
               filt_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   logic por_s;
   logic ext_s;
   logic bod_s;
   assign por_s = filt_q[sysctl_pkg::SYNC_POR];
   assign ext_s = filt_q[sysctl_pkg::SYNC_EXT];
   assign bod_s = filt_q[sysctl_pkg::SYNC_BOD];

   // ---- register decode
   logic sel_div;
   logic sel_flags;
   logic wr_div;
   logic wr_flags;
   logic ratio_ok;
   assign sel_div   = (reg_addr == sysctl_pkg::ADDR_PERIPHERAL_CLOCK_DIVIDER);
   assign sel_flags = (reg_addr == sysctl_pkg::ADDR_RESET_CAUSE_FLAGS);
   assign wr_div    = reg_wr && sel_div;
   assign wr_flags  = reg_wr && sel_flags;
   // only the low ratio bits are stored; upper bits are dropped
   assign ratio_ok  = (reg_wdata[sysctl_pkg::POS_RATIO_LSB +: sysctl_pkg::RATIO_WIDTH]
                       != sysctl_pkg::RATIO_RESERVED);                       // [R14] [R12]

   // ---- software clear strobes, one per flag position
   logic [sysctl_pkg::NUM_FLAGS-1:0] sw_clr;
   assign sw_clr = wr_flags ? reg_wdata[sysctl_pkg::NUM_FLAGS-1:0] :
                              {sysctl_pkg::NUM_FLAGS{1'b0}};                // [R1]

   // ---- set and clear causes per flag
   logic wdt_hit;
   assign wdt_hit = watchdog_timeout && watchdog_reset_enable;              // [R7]

   logic por_set;
   logic ext_set;
   logic ext_clr_hw;
   logic wdt_set;
   logic wdt_clr_hw;
   logic bod_set;
   // power-on forces the fixed image; other sets wait for it to negate
   assign por_set    = por_s;                                               // [R2] [R4]
   assign ext_set    = ext_s && !por_s;                                     // [R3] [R5]
   assign ext_clr_hw = por_s;                                               // [R5] [R6]
   assign wdt_set    = wdt_hit && !por_s;                                   // [R3] [R7]
   assign wdt_clr_hw = por_s || ext_s || bod_s;                             // [R8]
   assign bod_set    = bod_s && !por_s;                                     // [R9] [R11]

   // ---- next flag values; a hardware set always beats a software clear
   logic [sysctl_pkg::NUM_FLAGS-1:0] flags_q;
   logic [sysctl_pkg::NUM_FLAGS-1:0] flags_d;
   logic                             fl_por;
   logic                             fl_ext;
   logic                             fl_wdt;
   logic                             fl_bod;
   logic                             nx_por;
   logic                             nx_ext;
   logic                             nx_wdt;
   logic                             nx_bod;

   assign fl_por = flags_q[sysctl_pkg::POS_POWER_ON_FLAG];
   assign fl_ext = flags_q[sysctl_pkg::POS_EXTERNAL_PIN_RESET_FLAG];
   assign fl_wdt = flags_q[sysctl_pkg::POS_WATCHDOG_RESET_FLAG];
   assign fl_bod = flags_q[sysctl_pkg::POS_BROWNOUT_RESET_FLAG];

   // power-on flag moves only by power-on or software
   assign nx_por = por_set ? 1'b1 :                                         // [R18]
                   sw_clr[sysctl_pkg::POS_POWER_ON_FLAG] ? 1'b0 : fl_por;  // [R4]
   // external flag cleared by power-on, untouched by watchdog/brown-out
   assign nx_ext = ext_clr_hw ? 1'b0 :
                   ext_set ? 1'b1 :                                         // [R18]
                   sw_clr[sysctl_pkg::POS_EXTERNAL_PIN_RESET_FLAG] ? 1'b0 : fl_ext;
   // watchdog flag cleared by every other reset source
   assign nx_wdt = wdt_set ? 1'b1 :                                         // [R18]
                   wdt_clr_hw ? 1'b0 :                                      // [R8]
                   sw_clr[sysctl_pkg::POS_WATCHDOG_RESET_FLAG] ? 1'b0 : fl_wdt;
   // brown-out flag set by a dip and by the power-up ramp
   assign nx_bod = (por_set || bod_set) ? 1'b1 :                            // [R10] [R18]
                   sw_clr[sysctl_pkg::POS_BROWNOUT_RESET_FLAG] ? 1'b0 : fl_bod;

   // power-on applies the fixed image: bits 0 and 3 set, rest cleared
   assign flags_d = por_s ? sysctl_pkg::FLAGS_AT_POWER_ON :                 // [R2] [R10]
                            {nx_bod, nx_wdt, nx_ext, nx_por};

   // flag store survives chip reset; only power-on defines it
   always_ff @(posedge clock) begin
      flags_q <= flags_d;                                                   // [R1]
   end

   // ---- divider ratio register
   logic [1:0] ratio_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ratio_q <= sysctl_pkg::RATIO_RESET;                                // [R15]
      end else if (wr_div && ratio_ok) begin
         ratio_q <= reg_wdata[sysctl_pkg::POS_RATIO_LSB +: sysctl_pkg::RATIO_WIDTH]; // [R13]
      end
   end

   assign dvif.requested_ratio = ratio_q;

   pclk_divider u_div (
      .clock (clock),
      .rst_n (rst_n),
      .dv    (dvif.div)
   );

   assign pclk_en      = dvif.pclk_en;     // [R13]
   assign pclk_phase   = dvif.pclk_phase;
   assign active_ratio = dvif.active_ratio;

   // ---- pll hold: remember pll state on idle entry and keep it through idle
   logic pll_seen_q;
   logic keep_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pll_seen_q <= 1'b0;
         keep_q     <= 1'b0;
      end else begin
         if (!idle_mode) begin
            pll_seen_q <= pll_running;
         end
         keep_q <= idle_mode ? pll_seen_q : pll_running;                   // [R16]
      end
   end
   assign pll_keep_running = keep_q;

   // ---- read data; reserved and unmapped bits read zero
   logic [7:0] rd_mux;
   assign rd_mux = sel_div   ? {6'h00, ratio_q} :
                   sel_flags ? {4'h0, flags_q} :
                               8'h00;
   logic [7:0] rdata_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_q <= sysctl_pkg::RDATA_RESET;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end
   end
   assign reg_rdata = rdata_q;

endmodule // sysctl_reset_clock

// ### include/sysctl_pkg.sv
/*
 * Shared constants for the reset-cause record and peripheral clock divider:
 * register addresses, field positions, reset values, divider codes.
 * Assumes a single processor clock and full 32-bit register addresses.
 */
package sysctl_pkg;

   // register addresses on the peripheral bus
   localparam logic [31:0] ADDR_PERIPHERAL_CLOCK_DIVIDER = 32'he01fc100;
   localparam logic [31:0] ADDR_RESET_CAUSE_FLAGS        = 32'he01fc180;

   // reset-cause flag positions
   localparam int unsigned POS_POWER_ON_FLAG             = 0;
   localparam int unsigned POS_EXTERNAL_PIN_RESET_FLAG   = 1;
   localparam int unsigned POS_WATCHDOG_RESET_FLAG       = 2;
   localparam int unsigned POS_BROWNOUT_RESET_FLAG       = 3;
   localparam int unsigned NUM_FLAGS                     = 4;

   // divider field position and width
   localparam int unsigned POS_RATIO_LSB                 = 0;
   localparam int unsigned RATIO_WIDTH                   = 2;

   // divider codes
   localparam logic [1:0] RATIO_QUARTER                  = 2'h0;
   localparam logic [1:0] RATIO_FULL                     = 2'h1;
   localparam logic [1:0] RATIO_HALF                     = 2'h2;
   localparam logic [1:0] RATIO_RESERVED                 = 2'h3;

   // last count value of each divider period
   localparam logic [1:0] LAST_CNT_QUARTER               = 2'h3;
   localparam logic [1:0] LAST_CNT_HALF                  = 2'h1;
   localparam logic [1:0] LAST_CNT_FULL                  = 2'h0;

   // values after reset
   localparam logic [1:0] RATIO_RESET                    = 2'h0;
   localparam logic [7:0] RDATA_RESET                    = 8'h00;
   localparam logic [1:0] CNT_RESET                      = 2'h0;

   // flag image forced while power-on reset is asserted
   localparam logic [3:0] FLAGS_AT_POWER_ON              = 4'h9;

   // number of synchronised outside inputs and their bit positions
   localparam int unsigned NUM_SYNC                      = 3;
   localparam int unsigned SYNC_POR                      = 0;
   localparam int unsigned SYNC_EXT                      = 1;
   localparam int unsigned SYNC_BOD                      = 2;

endpackage

// ### include/clk_div_if.sv
/*
 * Carrier between the control top and the peripheral clock divider.
 * Assumes both ends run on the processor clock.
 */
`timescale 1ns/10ps
interface clk_div_if;
   logic [1:0] requested_ratio;   // ratio programmed by software
   logic [1:0] active_ratio;      // ratio currently in effect
   logic       pclk_en;           // one-cycle peripheral clock enable
   logic       pclk_phase;        // divided clock level

   modport ctrl (
      output requested_ratio,
      input  active_ratio,
      input  pclk_en,
      input  pclk_phase
   );
   modport div (
      input  requested_ratio,
      output active_ratio,
      output pclk_en,
      output pclk_phase
   );
endinterface

// ### src/pclk_divider.sv
/*
 * Peripheral clock divider: makes an enable pulse and a phase level
 * every one, two or four processor clocks.
 * Assumes the requested ratio never holds the reserved code.
 */
`timescale 1ns/10ps
module pclk_divider (
   input  wire logic clock,
   input  wire logic rst_n,
   clk_div_if.div    dv
);

   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [1:0] active_q;
   logic       en_q;
   logic       phase_q;
   logic [1:0] last_cnt;
   logic [1:0] new_last;
   logic       boundary;
   logic [1:0] half_cnt;

   // end of the current period for the ratio in effect
   assign last_cnt = (active_q == sysctl_pkg::RATIO_FULL) ? sysctl_pkg::LAST_CNT_FULL :
                     (active_q == sysctl_pkg::RATIO_HALF) ? sysctl_pkg::LAST_CNT_HALF :
                                                             sysctl_pkg::LAST_CNT_QUARTER;
   assign boundary = (cnt_q == last_cnt);
   // a new ratio is taken only at a period boundary, so no short pulse
   assign cnt_d    = boundary ? sysctl_pkg::CNT_RESET : cnt_q + 2'h1; // [R17]
   assign new_last = (dv.requested_ratio == sysctl_pkg::RATIO_FULL) ? sysctl_pkg::LAST_CNT_FULL :
                     (dv.requested_ratio == sysctl_pkg::RATIO_HALF) ? sysctl_pkg::LAST_CNT_HALF :
                                                      sysctl_pkg::LAST_CNT_QUARTER;
   // phase is high in the first half of each period
   assign half_cnt = boundary ? {1'b0, new_last[1]} : {1'b0, last_cnt[1]};

   // counter, ratio switch and outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_q    <= sysctl_pkg::CNT_RESET;
         active_q <= sysctl_pkg::RATIO_RESET;   // [R15]
         en_q     <= 1'b0;
         phase_q  <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         if (boundary) begin
            active_q <= dv.requested_ratio;    // [R17]
         end
         en_q     <= boundary;                  // [R13]
         phase_q  <= (cnt_d <= half_cnt);      // high for the first half of the period
      end
   end

   assign dv.active_ratio = active_q;
   assign dv.pclk_en      = en_q;
   assign dv.pclk_phase   = phase_q;

endmodule // pclk_divider

// ### testbench/sysctl_reset_clock_props.sv
/*
 * Checker for the reset-cause record and peripheral clock divider top.
 * Assumes it is bound onto sysctl_reset_clock and sees only its ports.
 */
`timescale 1ns/10ps
module sysctl_reset_clock_props (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        idle_mode,
   input wire logic        pll_running,
   input wire logic        pll_keep_running,
   input wire logic        pclk_en,
   input wire logic        pclk_phase,
   input wire logic [1:0]  active_ratio
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // register port decode
   wire div_hit = reg_addr == sysctl_pkg::ADDR_PERIPHERAL_CLOCK_DIVIDER;
   wire map_hit = div_hit || reg_addr == sysctl_pkg::ADDR_RESET_CAUSE_FLAGS;
   wire div_rd  = reg_rd && div_hit;
   wire div_wr  = reg_wr && div_hit;

   a_ratio_after_reset: assert property ($rose(rst_n) |-> active_ratio == 2'h0)
      else $error("ratio not quarter after reset");
   a_div_readback: assert property ((div_wr && reg_wdata[1:0] != 2'h3) ##1 (div_rd && !reg_wr)
      |=> reg_rdata == {6'h00, $past(reg_wdata[1:0], 2)})
      else $error("divider readback differs from write");
   a_reserved_kept: assert property (div_rd ##1 (div_wr && reg_wdata[1:0] == 2'h3) ##1 div_rd
      |=> reg_rdata == $past(reg_rdata, 2))
      else $error("reserved ratio write took effect");
   a_unmapped_zero: assert property (reg_rd && !map_hit |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_full_rate: assert property (active_ratio == 2'h1 [*3] |-> pclk_en && pclk_phase)
      else $error("full rate enable or phase missing");
   a_half_rate: assert property (pclk_en && active_ratio == 2'h2 |=> !pclk_en ##1 pclk_en)
      else $error("half rate period wrong");
   a_quarter_rate: assert property (pclk_en && active_ratio == 2'h0
      |=> !pclk_en [*3] ##1 pclk_en)
      else $error("quarter rate period wrong");
   a_quarter_phase: assert property (pclk_en && active_ratio == 2'h0
      |-> pclk_phase ##1 pclk_phase ##1 !pclk_phase ##1 !pclk_phase)
      else $error("quarter rate phase not half high");
   a_switch_boundary: assert property ($changed(active_ratio) |-> pclk_en)
      else $error("ratio changed inside a period");
   a_pll_follow: assert property (!idle_mode |=> pll_keep_running == $past(pll_running))
      else $error("pll keep flag does not follow pll");
   a_pll_hold_idle: assert property (idle_mode [*3] |=> $stable(pll_keep_running))
      else $error("pll keep flag moved in idle");

   // main scenarios reached
   c_ratio_switch: cover property ($changed(active_ratio));
   c_reserved_write: cover property (div_wr && reg_wdata[1:0] == 2'h3);
   c_idle_hold: cover property (idle_mode [*3]);
endmodule // sysctl_reset_clock_props

// ### testbench/tb_top.sv
/*
 * Self-checking bench: reset-cause flags, register port and divider rate.
 * Assumes the package, interface, design and checker are compiled first.
 */
`timescale 1ns/10ps
module tb_top;
   localparam logic [31:0] DIV_A = sysctl_pkg::ADDR_PERIPHERAL_CLOCK_DIVIDER;
   localparam logic [31:0] FLG_A = sysctl_pkg::ADDR_RESET_CAUSE_FLAGS;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        por_active = 1'b1;
   logic        ext_reset_active = 1'b1;
   logic        supply_below_threshold = 1'b0;
   logic        watchdog_timeout = 1'b0;
   logic        watchdog_reset_enable = 1'b0;
   logic        idle_mode = 1'b0;
   logic        pll_running = 1'b1;
   logic        pll_keep_running, pclk_en, pclk_phase;
   logic [1:0]  active_ratio, ratio;
   logic [7:0]  d, v, n;
   int          n_mismatch = 0, total_checks = 0, seed = 39, last_op = 0;

   sysctl_reset_clock sysctl_reset_clock_i (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .por_active, .ext_reset_active, .supply_below_threshold,
      .watchdog_timeout, .watchdog_reset_enable, .idle_mode, .pll_running,
      .pll_keep_running, .pclk_en, .pclk_phase, .active_ratio);

   // processor clock, 8 ns period
   always #4 clock = ~clock;

   // power-mode inputs wander at random
   always @(posedge clock) begin
      #1;
      if ($random(seed) % 8 == 0) idle_mode = ~idle_mode;
      if ($random(seed) % 4 == 0) pll_running = ~pll_running;
   end

   function automatic logic [1:0] next_ratio(input logic [1:0] old, input logic [7:0] w);
      return (w[1:0] == 2'h3) ? old : w[1:0];
   endfunction
   function automatic logic [7:0] period_of(input logic [1:0] r);
      return (r == 2'h1) ? 8'h01 : (r == 2'h2) ? 8'h02 : 8'h04;
   endfunction

   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // same-kind accesses get one idle edge between them
   task automatic wr(input logic [31:0] a, input logic [7:0] w);
      if (last_op == 2) tick(1);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      last_op = 2;
   endtask
   task automatic rd(input logic [31:0] a);
      if (last_op == 1) tick(1);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      d = reg_rdata;
      last_op = 1;
   endtask
   task automatic flags(input logic [7:0] exp);
      rd(FLG_A);
      chk("reset_cause_flags", exp, d);
   endtask
   // source held for c cycles, then time for the synchronisers
   task automatic pulse(ref logic s, input int c);
      s = 1'b1;
      tick(c);
      s = 1'b0;
      tick(8);
   endtask
   // cycles from one peripheral enable pulse to the next
   task automatic measure(output logic [7:0] p);
      p = 8'h00;
      while (pclk_en !== 1'b1 && p < 8'd20) begin
         tick(1);
         p++;
      end
      p = 8'h00;
      do begin
         tick(1);
         p++;
      end while (pclk_en !== 1'b1 && p < 8'd20);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // main sequence: flags first, then divider, then a second reset
   initial begin
      tick(6);
      rst_n = 1'b1;
      tick(1);
      flags(8'h09);
      por_active = 1'b0;
      tick(8);
      flags(8'h0b);
      wr(FLG_A, 8'h02);
      tick(2);
      flags(8'h0b);
      ext_reset_active = 1'b0;
      tick(8);
      wr(FLG_A, 8'h02);
      flags(8'h09);
      wr(FLG_A, 8'h01);
      flags(8'h08);
      pulse(watchdog_timeout, 1);
      flags(8'h08);
      watchdog_reset_enable = 1'b1;
      pulse(watchdog_timeout, 1);
      flags(8'h0c);
      pulse(ext_reset_active, 8);
      flags(8'h0a);
      pulse(watchdog_timeout, 1);
      flags(8'h0e);
      wr(FLG_A, 8'h08);
      flags(8'h06);
      pulse(supply_below_threshold, 8);
      flags(8'h0a);
      wr(32'he01fc104, 8'h02);
      rd(32'he01fc104);
      chk("unmapped_read", 8'h00, d);
      ratio = 2'h0;
      for (int i = 0; i < 16; i++) begin
         // all four codes first, then random ones, upper bits zero
         v = (i < 4) ? 8'(i) : 8'($random(seed)) & 8'h03;
         rd(DIV_A);
         chk("divider_before", {6'h00, ratio}, d);
         wr(DIV_A, v);
         ratio = next_ratio(ratio, v);
         rd(DIV_A);
         chk("divider_after", {6'h00, ratio}, d);
         for (int k = 0; k < 12 && active_ratio !== ratio; k++) tick(1);
         chk("active_ratio", {6'h00, ratio}, {6'h00, active_ratio});
         measure(n);
         chk("pclk_period", period_of(ratio), n);
      end
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      flags(8'h0a);
      rd(DIV_A);
      chk("divider_reset", 8'h00, d);
      measure(n);
      chk("pclk_period_reset", 8'h04, n);
      finish_test;
   end

   // cut a hang short
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
endmodule // tb_top

bind sysctl_reset_clock sysctl_reset_clock_props sysctl_reset_clock_props_i (.clock, .rst_n,
   .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .idle_mode, .pll_running,
   .pll_keep_running, .pclk_en, .pclk_phase, .active_ratio);
